//--- rtl/ces_defines.vh
// Constants for the critical-event status logic
`ifndef CES_DEFINES_VH
`define CES_DEFINES_VH

// ==========================================================
// Register map (byte addresses)
`define CES_ADDR_W          8
`define CES_OFF_EVENT       8'h30
`define CES_OFF_IRQ_STAT    8'h34
`define CES_OFF_IRQ_MASK    8'h38
`define CES_OFF_FLAGS       8'h3c

// ==========================================================
// Field layout of the event register
`define CES_NEV             15
`define CES_SEL_LSB         0
`define CES_RSP_LSB         16
`define CES_EVENT_RESET     32'h0000_0000

// ==========================================================
// Event numbers
`define CES_EV_AUTOCAL      0
`define CES_EV_ITHR_FALL    1
`define CES_EV_ITHR_RISE    2
`define CES_EV_IBUF_ERR     3
`define CES_EV_BURST_START  4
`define CES_EV_BURST_DONE   5
`define CES_EV_IN_CLK       6
`define CES_EV_OUT_CLK      7
`define CES_EV_DIO0_RISE    8
`define CES_EV_OTHR_FALL    9
`define CES_EV_OTHR_RISE    10
`define CES_EV_LRDY_FALL    11
`define CES_EV_LRDY_RISE    12
`define CES_EV_OBURST_RDY   13
`define CES_EV_OBUF_ERR     14

// ==========================================================
// Interrupt events (status/mask layout)
`define CES_NIRQ            2
`define CES_IRQ_RESPONSE    0
`define CES_IRQ_ACK_MISS    1

`endif

//--- rtl/ces_edge_detect.v
// Per-bit edge detector producing rise and fall pulses
`timescale 1ns/1ns
`default_nettype none

module ces_edge_detect #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire [W-1:0] level,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);

    reg [W-1:0] prev_r;

    // ==========================================================
    // Previous-level store; reset low so a high level at reset counts as a rise
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_r <= {W{1'b0}};
        end else begin
            prev_r <= level;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_edge
            assign rise[i] = level[i] & ~prev_r[i];
            assign fall[i] = ~level[i] & prev_r[i];
        end
    endgenerate

endmodule // ces_edge_detect

`default_nettype wire

//--- rtl/ces_event_status.v
// Critical-event select/response register with APB slave and interrupt
//
// How it works
// - Select bit n gates response bit n+16; unselected events never set responses.
// - A set response bit holds until software clears it.
// - Input threshold flag falling edge is event 1, rising edge event 2.
// - Input buffer overflow or underflow is one combined event 3.
// - Burst-busy rise is event 4, its fall event 5.
// - Each input sample clock is event 6, each output clock event 7.
// - Digital port line zero rising edge is event 8; falls ignored.
// - Output threshold flag fall is event 9, rise event 10.
// - Load-ready flag fall is event 11, rise event 12.
// - Output becoming ready for a burst trigger is event 13.
// - Output buffer overflow or frame overflow is combined event 14.
// - The event register sits at offset 0x30.
// - Input threshold flag high while stored count exceeds threshold.
// - Load-ready sets when frame index passes zero in circular load.
// - Output overflow arises on a write into a full output buffer.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ces_defines.vh"

module ces_event_status #(
    parameter CNT_W = 19
) (
    input  wire             CLK,
    input  wire             RSTN,
    // APB slave
    input  wire             PSEL,
    input  wire             PENABLE,
    input  wire             PWRITE,
    input  wire [7:0]       PADDR,
    input  wire [31:0]      PWDATA,
    output reg  [31:0]      PRDATA,
    output reg              PREADY,
    output reg              PSLVERR,
    // Event sources
    input  wire             AUTOCAL_DONE,
    input  wire [CNT_W-1:0] IN_BUF_COUNT,
    input  wire [CNT_W-1:0] IN_BUF_THRESHOLD,
    input  wire             IN_BUF_OVERFLOW,
    input  wire             IN_BUF_UNDERFLOW,
    input  wire             IN_BURST_BUSY,
    input  wire             IN_SAMPLE_CLK,
    input  wire             OUT_SAMPLE_CLK,
    input  wire             DIGITAL_PORT_LINE_ZERO,
    input  wire             OUT_BUF_THRESHOLD,
    input  wire             CIRC_MODE,
    input  wire             LOAD_REQ,
    input  wire             FRAME_INDEX_ZERO,
    input  wire             OUT_BURST_READY,
    input  wire             OUT_BUF_WRITE,
    input  wire             OUT_BUF_FULL,
    input  wire             OUT_FRAME_OVERFLOW,
    // Status outputs
    output reg              IN_THRESHOLD_FLAG,
    output reg              LOAD_READY,
    output reg              IRQ
);

    localparam NEV = `CES_NEV;
    localparam NIRQ = `CES_NIRQ;

    // ==========================================================
    // Registers
    reg  [NEV-1:0]  sel_r;
    reg  [NEV-1:0]  rsp_r;
    reg  [NEV-1:0]  rsp_nxt;
    reg  [NIRQ-1:0] irq_stat_r;
    reg  [NIRQ-1:0] irq_stat_nxt;
    reg  [NIRQ-1:0] irq_mask_r;

    wire            load_ready_w;
    wire [NEV-1:0]  ev;
    wire [5:0]      lvl;
    wire [5:0]      lvl_rise;
    wire [5:0]      lvl_fall;
    wire            ithr_w;
    wire            obuf_ovf;

    // ==========================================================
    // Bus decode; single-cycle access phase, no wait states
    wire            acc     = PSEL & PENABLE;
    wire            wr      = acc & PWRITE;
    wire            hit_ev  = (PADDR == `CES_OFF_EVENT);
    wire            hit_st  = (PADDR == `CES_OFF_IRQ_STAT);
    wire            hit_mk  = (PADDR == `CES_OFF_IRQ_MASK);
    wire            hit_fl  = (PADDR == `CES_OFF_FLAGS);
    wire            mapped  = hit_ev | hit_st | hit_mk | hit_fl;

    // ==========================================================
    // Flag derivation
    assign ithr_w   = (IN_BUF_COUNT > IN_BUF_THRESHOLD);
    assign obuf_ovf = OUT_BUF_WRITE & OUT_BUF_FULL;

    ces_load_ready u_load_ready (
        .clk              (CLK),
        .rstn             (RSTN),
        .circ_mode        (CIRC_MODE),
        .load_req         (LOAD_REQ),
        .frame_index_zero (FRAME_INDEX_ZERO),
        .load_ready       (load_ready_w)
    );

    // Levels whose edges are events
    assign lvl = {OUT_BURST_READY, load_ready_w, OUT_BUF_THRESHOLD,
                  DIGITAL_PORT_LINE_ZERO, IN_BURST_BUSY, ithr_w};

    ces_edge_detect #(
        .W (6)
    ) u_edges (
        .clk   (CLK),
        .rstn  (RSTN),
        .level (lvl),
        .rise  (lvl_rise),
        .fall  (lvl_fall)
    );

    // ==========================================================
    // Event vector
    assign ev[`CES_EV_AUTOCAL]     = AUTOCAL_DONE;
    assign ev[`CES_EV_ITHR_FALL]   = lvl_fall[0];
    assign ev[`CES_EV_ITHR_RISE]   = lvl_rise[0];
    assign ev[`CES_EV_IBUF_ERR]    = IN_BUF_OVERFLOW | IN_BUF_UNDERFLOW;
    assign ev[`CES_EV_BURST_START] = lvl_rise[1];
    assign ev[`CES_EV_BURST_DONE]  = lvl_fall[1];
    assign ev[`CES_EV_IN_CLK]      = IN_SAMPLE_CLK;
    assign ev[`CES_EV_OUT_CLK]     = OUT_SAMPLE_CLK;
    assign ev[`CES_EV_DIO0_RISE]   = lvl_rise[2];
    assign ev[`CES_EV_OTHR_FALL]   = lvl_fall[3];
    assign ev[`CES_EV_OTHR_RISE]   = lvl_rise[3];
    assign ev[`CES_EV_LRDY_FALL]   = lvl_fall[4];
    assign ev[`CES_EV_LRDY_RISE]   = lvl_rise[4];
    assign ev[`CES_EV_OBURST_RDY]  = lvl_rise[5];
    assign ev[`CES_EV_OBUF_ERR]    = obuf_ovf | OUT_FRAME_OVERFLOW;

    // ==========================================================
    // Response bits: write-zero clears, event set wins over clear
    wire wr_ev = wr & hit_ev;
    wire [NEV-1:0] wr_rsp = PWDATA[`CES_RSP_LSB +: NEV];
    wire [NEV-1:0] rsp_set = ev & sel_r;

    always @* begin
        rsp_nxt = rsp_r;
        if (wr_ev) begin
            rsp_nxt = rsp_r & wr_rsp;
        end
        rsp_nxt = rsp_nxt | rsp_set;
    end

    wire any_new_rsp = |(rsp_set & ~rsp_r);
    wire ack_miss    = |(rsp_set & rsp_r);

    // ==========================================================
    // Interrupt status: sticky, write-one-to-clear, set wins
    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (wr & hit_st) begin
            irq_stat_nxt = irq_stat_r & ~PWDATA[NIRQ-1:0];
        end
        irq_stat_nxt[`CES_IRQ_RESPONSE] = irq_stat_nxt[`CES_IRQ_RESPONSE] | any_new_rsp;
        irq_stat_nxt[`CES_IRQ_ACK_MISS] = irq_stat_nxt[`CES_IRQ_ACK_MISS] | ack_miss;
    end

    // ==========================================================
    // Register update
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sel_r      <= {NEV{1'b0}};
            rsp_r      <= {NEV{1'b0}};
            irq_stat_r <= {NIRQ{1'b0}};
            irq_mask_r <= {NIRQ{1'b0}};
        end else begin
            rsp_r      <= rsp_nxt;
            irq_stat_r <= irq_stat_nxt;
            if (wr_ev) begin
                sel_r     <= PWDATA[`CES_SEL_LSB +: NEV];
            end
            if (wr & hit_mk) begin
                irq_mask_r <= PWDATA[NIRQ-1:0];
            end
        end
    end

    // ==========================================================
    // Read data and response, registered; PREADY answers in the access cycle
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h0000_0000;
        if (hit_ev) begin
            // Reserved event has no select or response flops, so bits 15 and 31 always read low
            rd_nxt = {1'b0, rsp_r, 1'b0, sel_r};
        end else if (hit_st) begin
            rd_nxt[NIRQ-1:0] = irq_stat_r;
        end else if (hit_mk) begin
            rd_nxt[NIRQ-1:0] = irq_mask_r;
        end else if (hit_fl) begin
            rd_nxt[1:0] = {load_ready_w, ithr_w};
        end
    end

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~mapped;
            PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? rd_nxt : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Status pins, registered copies
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IN_THRESHOLD_FLAG <= 1'b0;
            LOAD_READY        <= 1'b0;
            IRQ               <= 1'b0;
        end else begin
            IN_THRESHOLD_FLAG <= ithr_w;
            LOAD_READY        <= load_ready_w;
            IRQ               <= |(irq_stat_nxt & irq_mask_r);
        end
    end

endmodule // ces_event_status

`default_nettype wire

//--- rtl/ces_load_ready.v
// Output circular-buffer load-ready flag
`timescale 1ns/1ns
`default_nettype none

module ces_load_ready (
    input  wire clk,
    input  wire rstn,
    input  wire circ_mode,
    input  wire load_req,
    input  wire frame_index_zero,
    output wire load_ready
);

    reg ready_r;
    reg ready_nxt;

    // ==========================================================
    // Set on frame index wrap with circular mode and request; drops with request
    always @* begin
        ready_nxt = ready_r;
        if (!circ_mode || !load_req) begin
            ready_nxt = 1'b0;
        end else if (frame_index_zero) begin
            ready_nxt = 1'b1;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= ready_nxt;
        end
    end

    assign load_ready = ready_r;

endmodule // ces_load_ready

`default_nettype wire

//--- sim/ces_event_status_props.sv
// Port-level assertions for the critical-event status logic
`timescale 1ns/1ns
`default_nettype none
`include "ces_defines.vh"

module ces_event_status_props #(
    parameter CNT_W = 19
) (
    input wire logic             CLK,
    input wire logic             RSTN,
    input wire logic             PSEL,
    input wire logic             PENABLE,
    input wire logic             PWRITE,
    input wire logic [7:0]       PADDR,
    input wire logic [31:0]      PRDATA,
    input wire logic             PREADY,
    input wire logic             PSLVERR,
    input wire logic [CNT_W-1:0] IN_BUF_COUNT,
    input wire logic [CNT_W-1:0] IN_BUF_THRESHOLD,
    input wire logic             CIRC_MODE,
    input wire logic             LOAD_REQ,
    input wire logic             FRAME_INDEX_ZERO,
    input wire logic             IN_THRESHOLD_FLAG,
    input wire logic             LOAD_READY
);
    // ==========
    // Helpers
    logic mapped;
    assign mapped = PADDR == `CES_OFF_EVENT || PADDR == `CES_OFF_IRQ_STAT
                 || PADDR == `CES_OFF_IRQ_MASK || PADDR == `CES_OFF_FLAGS;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // ==========
    // Bus timing
    AST_RDY_FIRST: assert property (PSEL && PENABLE && $past(PSEL) && !$past(PENABLE) |-> PREADY)
        else $error("no ready in first access cycle");
    AST_RDY_ONE: assert property (PREADY |=> !PREADY)
        else $error("ready held over one cycle");
    AST_ERR_RDY: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    AST_ERR_UNMAP: assert property (PREADY && !mapped |-> PSLVERR)
        else $error("unmapped access not refused");
    AST_ERR_MAP: assert property (PREADY && mapped |-> !PSLVERR)
        else $error("mapped access refused");
    AST_RD_IDLE: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer");
    AST_RSVD: assert property (PREADY && !PWRITE && PADDR == `CES_OFF_EVENT |->
        PRDATA[15] == 1'b0 && PRDATA[31] == 1'b0)
        else $error("reserved event bits read high");

    // ==========
    // Flags
    AST_THR: assert property ($past(RSTN) |->
        IN_THRESHOLD_FLAG == $past(IN_BUF_COUNT > IN_BUF_THRESHOLD))
        else $error("threshold flag wrong");
    AST_LRDY: assert property ($rose(LOAD_READY) |->
        $past(FRAME_INDEX_ZERO, 2) && $past(CIRC_MODE, 2) && $past(LOAD_REQ, 2))
        else $error("load ready rose without cause");
endmodule // ces_event_status_props

bind ces_event_status ces_event_status_props #(.CNT_W(CNT_W)) u_props (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IN_BUF_COUNT(IN_BUF_COUNT), .IN_BUF_THRESHOLD(IN_BUF_THRESHOLD),
    .CIRC_MODE(CIRC_MODE), .LOAD_REQ(LOAD_REQ), .FRAME_INDEX_ZERO(FRAME_INDEX_ZERO),
    .IN_THRESHOLD_FLAG(IN_THRESHOLD_FLAG), .LOAD_READY(LOAD_READY));
`default_nettype wire

//--- sim/tb_critical_event_status_logic.sv
// Self-checking bench for the critical-event status logic
`timescale 1ns/1ns
`default_nettype none
`include "ces_defines.vh"

module tb_critical_event_status_logic;
    logic        CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic        PREADY, PSLVERR, IN_THRESHOLD_FLAG, LOAD_READY, IRQ, err;
    logic [14:0] ev = 15'h0;
    logic        uf = 0, fz = 0, dio = 0, obw = 0, obf = 0;
    logic [18:0] cnt = 19'h0, thr = 19'h3;
    int          mismatches = 0, n_tests = 0;
    // Row: event number is the index, expected response bit the value
    int          rsp [15] = '{16, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27, 28, 29, 30};

    always #5 CLK = ~CLK;

    ces_event_status u_dut (
        .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .AUTOCAL_DONE(ev[0]), .IN_BUF_COUNT((ev[1] | ev[2]) ? 19'h5 : cnt),
        .IN_BUF_THRESHOLD(thr), .IN_BUF_OVERFLOW(ev[3]), .IN_BUF_UNDERFLOW(uf),
        .IN_BURST_BUSY(ev[4] | ev[5]), .IN_SAMPLE_CLK(ev[6]), .OUT_SAMPLE_CLK(ev[7]),
        .DIGITAL_PORT_LINE_ZERO(ev[8] | dio), .OUT_BUF_THRESHOLD(ev[9] | ev[10]),
        .CIRC_MODE(ev[11] | ev[12]), .LOAD_REQ(ev[11] | ev[12]), .FRAME_INDEX_ZERO(fz),
        .OUT_BURST_READY(ev[13]), .OUT_BUF_WRITE(obw), .OUT_BUF_FULL(obf),
        .OUT_FRAME_OVERFLOW(ev[14]), .IN_THRESHOLD_FLAG(IN_THRESHOLD_FLAG),
        .LOAD_READY(LOAD_READY), .IRQ(IRQ));

    // ==========
    // Tasks
    task stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Called just after a rising edge; extra idle edges let registered flags settle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        do begin
            @(posedge CLK);
            t++;
        end while (PREADY !== 1'b1 && t < 20);
        if (PREADY !== 1'b1)
            mismatches++;
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        repeat (2) @(posedge CLK);
    endtask

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    // Level sources make both edges; frame-zero pulses inside the load window
    task fire(input int i);
        ev[i] <= 1;
        @(posedge CLK);
        fz <= (i == 11 || i == 12);
        @(posedge CLK);
        fz <= 0;
        @(posedge CLK);
        ev[i] <= 0;
        repeat (4) @(posedge CLK);
    endtask

    // ==========
    // Sequence
    initial begin
        #100000;
        mismatches++;
        stop_test;
    end

    initial begin
        repeat (5) @(posedge CLK);
        RSTN <= 1;
        @(posedge CLK);
        chk("irq_rst", IRQ, 0);
        rdc("event_rst", `CES_OFF_EVENT, `CES_EVENT_RESET);
        rdc("mask_rst", `CES_OFF_IRQ_MASK, 0);
        for (int i = 0; i < 15; i++) begin
            apb(1, `CES_OFF_EVENT, 32'h1 << i);
            fire(i);
            rdc("resp", `CES_OFF_EVENT, (32'h1 << i) | (32'h1 << rsp[i]));
            apb(1, `CES_OFF_EVENT, (32'h1 << i) | (32'h1 << rsp[i]));
            rdc("keep", `CES_OFF_EVENT, (32'h1 << i) | (32'h1 << rsp[i]));
            apb(1, `CES_OFF_EVENT, 32'h0);
            fire(i);
            rdc("unsel", `CES_OFF_EVENT, 0);
        end
        // Load-ready flag seen on its pin and in the flags word
        ev[11] <= 1;
        @(posedge CLK);
        fz <= 1;
        @(posedge CLK);
        fz <= 0;
        repeat (2) @(posedge CLK);
        chk("lrdy_set", LOAD_READY, 1);
        rdc("flags_lrdy", `CES_OFF_FLAGS, 32'h2);
        ev[11] <= 0;
        repeat (3) @(posedge CLK);
        chk("lrdy_drop", LOAD_READY, 0);
        dio <= 1;
        repeat (3) @(posedge CLK);
        apb(1, `CES_OFF_EVENT, 32'h100);
        dio <= 0;
        repeat (3) @(posedge CLK);
        rdc("dio_fall", `CES_OFF_EVENT, 32'h100);
        apb(1, `CES_OFF_EVENT, 32'h4008);
        uf <= 1;
        obf <= 1;
        @(posedge CLK);
        uf <= 0;
        repeat (2) @(posedge CLK);
        rdc("uflow", `CES_OFF_EVENT, 32'h0008_4008);
        obw <= 1;
        @(posedge CLK);
        obw <= 0;
        obf <= 0;
        repeat (2) @(posedge CLK);
        rdc("full_wr", `CES_OFF_EVENT, 32'h4008_4008);
        cnt <= 19'h3;
        repeat (2) @(posedge CLK);
        chk("thr_eq", IN_THRESHOLD_FLAG, 0);
        cnt <= 19'h4;
        repeat (2) @(posedge CLK);
        chk("thr_gt", IN_THRESHOLD_FLAG, 1);
        rdc("flags", `CES_OFF_FLAGS, 32'h1);
        thr <= 19'h4;
        repeat (2) @(posedge CLK);
        chk("thr_move", IN_THRESHOLD_FLAG, 0);
        cnt <= 19'h0;
        thr <= 19'h3;
        apb(1, `CES_OFF_IRQ_STAT, 32'h3);
        rdc("stat_clr", `CES_OFF_IRQ_STAT, 0);
        apb(1, `CES_OFF_IRQ_MASK, 32'h1);
        apb(1, `CES_OFF_EVENT, 32'h1);
        chk("irq_idle", IRQ, 0);
        fire(0);
        chk("irq_set", IRQ, 1);
        rdc("stat", `CES_OFF_IRQ_STAT, 32'h3);
        apb(1, `CES_OFF_IRQ_STAT, 32'h1);
        chk("irq_clr", IRQ, 0);
        rdc("stat_w1c", `CES_OFF_IRQ_STAT, 32'h2);
        apb(1, `CES_OFF_IRQ_MASK, 32'h2);
        chk("irq_mask", IRQ, 1);
        rdc("resp_hold", `CES_OFF_EVENT, 32'h0001_0001);
        apb(1, 8'h40, 32'hffff_ffff);
        chk("slverr_w", err, 1);
        rdc("unmapped", 8'h40, 0);
        chk("slverr_r", err, 1);
        // Mid-run reset while the interrupt is up
        RSTN <= 0;
        repeat (2) @(posedge CLK);
        RSTN <= 1;
        @(posedge CLK);
        chk("irq_rst2", IRQ, 0);
        rdc("event_rst2", `CES_OFF_EVENT, `CES_EVENT_RESET);
        rdc("stat_rst2", `CES_OFF_IRQ_STAT, 0);
        stop_test;
    end
endmodule // tb_critical_event_status_logic
`default_nettype wire
